// ===== hw/age_ctrl.sv
// Automatic gain and exposure controller with APB register access
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module age_ctrl
   import age_pkg::*;
#(
   parameter logic [AGE_GW-1:0] GAIN_ABS_MIN  = 12'h000,
   parameter logic [AGE_GW-1:0] GAIN_ABS_MAX  = 12'hfff,
   parameter logic [AGE_EW-1:0] EXP_MODEL_MIN = 24'h000014,
   parameter logic [AGE_EW-1:0] EXP_MODEL_MAX = 24'h98967f
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   input  wire age_pix_t    pix,
   input  wire age_rect_t   stat_region,
   input  wire age_rect_t   image_region,
   input  wire logic [AGE_GW-1:0] gain_range_lo,
   input  wire logic [AGE_GW-1:0] gain_range_hi,
   output age_apply_t       apply
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      age_mode_t         gmode;
      age_mode_t         emode;
      logic              profile;
      logic              trigw;
      logic [7:0]        target;
      logic [7:0]        damp;
      logic [AGE_GW-1:0] gain_lo;
      logic [AGE_GW-1:0] gain_hi;
      logic [AGE_EW-1:0] exp_lo;
      logic [AGE_EW-1:0] exp_hi;
      logic [AGE_EW-1:0] frame_min;
      logic [AGE_GW-1:0] gain_cur;
      logic [AGE_EW-1:0] exp_cur;
      logic [AGE_SW-1:0] sum;
      logic [AGE_SW-1:0] cnt;
      logic [7:0]        avg;
      logic              avg_ok;
      logic              stats_new;
      age_apply_t        apply;
      logic [31:0]       rdata;
   } age_state_t;

   age_state_t st_r;
   age_state_t st_nxt;

   logic              wr_en;
   logic              rd_en;
   logic              in_win;
   logic              overlap;
   logic [AGE_CW:0]   ix0, ix1, iy0, iy1;
   logic [AGE_GW-1:0] glo_c, ghi_c;
   logic [AGE_EW-1:0] elo_c, ehi_c;
   logic              g_act, e_act, exp_na, at_target, brighter;
   logic [8:0]        err;
   logic [16:0]       step;
   logic [AGE_EW-1:0] estep;
   logic [AGE_GW-1:0] gstep;
   logic [AGE_EW:0]   etmp;
   logic [AGE_GW:0]   gtmp;
   logic              use_gain;

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign prdata  = st_r.rdata;
   assign apply   = st_r.apply;

   ////////////////////////////////////////////////////////////////////////////
   // Region intersection and bound clamping
   always_comb
   begin
      ix0 = {1'b0, (stat_region.x0 > image_region.x0) ? stat_region.x0 : image_region.x0};
      iy0 = {1'b0, (stat_region.y0 > image_region.y0) ? stat_region.y0 : image_region.y0};
      ix1 = ({1'b0, stat_region.x0} + {1'b0, stat_region.w} < {1'b0, image_region.x0} + {1'b0, image_region.w})
          ? {1'b0, stat_region.x0} + {1'b0, stat_region.w} : {1'b0, image_region.x0} + {1'b0, image_region.w};
      iy1 = ({1'b0, stat_region.y0} + {1'b0, stat_region.h} < {1'b0, image_region.y0} + {1'b0, image_region.h})
          ? {1'b0, stat_region.y0} + {1'b0, stat_region.h} : {1'b0, image_region.y0} + {1'b0, image_region.h};
      overlap = (ix1 > ix0) && (iy1 > iy0);
      in_win  = overlap && ({1'b0, pix.x} >= ix0) && ({1'b0, pix.x} < ix1)
                && ({1'b0, pix.y} >= iy0) && ({1'b0, pix.y} < iy1);
      glo_c = (st_r.gain_lo < gain_range_lo) ? gain_range_lo : st_r.gain_lo;
      ghi_c = (st_r.gain_hi > gain_range_hi) ? gain_range_hi : st_r.gain_hi;
      elo_c = (st_r.exp_lo < EXP_MODEL_MIN) ? EXP_MODEL_MIN : st_r.exp_lo;
      ehi_c = (st_r.exp_hi > EXP_MODEL_MAX) ? EXP_MODEL_MAX : st_r.exp_hi;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Loop arithmetic
   always_comb
   begin
      exp_na    = st_r.trigw;
      g_act     = (st_r.gmode != AGE_OFF);
      e_act     = (st_r.emode != AGE_OFF) && !exp_na;
      at_target = (st_r.avg == st_r.target);
      brighter  = (st_r.avg < st_r.target);
      err       = brighter ? {1'b0, st_r.target} - {1'b0, st_r.avg}
                           : {1'b0, st_r.avg} - {1'b0, st_r.target};
      step      = {8'h00, err} * {9'h000, st_r.damp};
      gstep     = (step[16:8] == 9'h000) ? {{(AGE_GW-1){1'b0}}, 1'b1} : AGE_GW'(step[16:8]);
      estep     = (step[16:8] == 9'h000) ? {{(AGE_EW-1){1'b0}}, 1'b1} : AGE_EW'({step[16:8], 3'b000});
      // Combined run: minimised quantity rises only once the other is pinned, and falls first
      use_gain  = g_act;
      if (g_act && e_act && st_r.profile)
         use_gain = brighter ? (st_r.exp_cur >= ehi_c) : (st_r.gain_cur > glo_c);
      if (g_act && e_act && !st_r.profile)
         use_gain = brighter ? (st_r.gain_cur < ghi_c) : (st_r.exp_cur <= elo_c);
      gtmp = brighter ? {1'b0, st_r.gain_cur} + {1'b0, gstep}
                      : {1'b0, st_r.gain_cur} - {1'b0, gstep};
      etmp = brighter ? {1'b0, st_r.exp_cur} + {1'b0, estep}
                      : {1'b0, st_r.exp_cur} - {1'b0, estep};
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_nxt           = st_r;
      st_nxt.stats_new = 1'b0;
      // Register writes
      if (wr_en)
      begin
         case (paddr)
            AGE_REG_CTRL:
            begin
               st_nxt.gmode   = age_mode_t'(pwdata[AGE_CTRL_GMODE_LSB +: 2]);
               st_nxt.emode   = age_mode_t'(pwdata[AGE_CTRL_EMODE_LSB +: 2]);
               st_nxt.profile = pwdata[AGE_CTRL_PROFILE];
               st_nxt.trigw   = pwdata[AGE_CTRL_TRIGW];
            end
            AGE_REG_TARGET:    st_nxt.target    = pwdata[7:0];
            AGE_REG_GAIN_MAN:  st_nxt.gain_cur  = pwdata[AGE_GW-1:0];
            AGE_REG_GAIN_LO:   st_nxt.gain_lo   = pwdata[AGE_GW-1:0];
            AGE_REG_GAIN_HI:   st_nxt.gain_hi   = pwdata[AGE_GW-1:0];
            AGE_REG_EXP_MAN:   st_nxt.exp_cur   = pwdata[AGE_EW-1:0];
            AGE_REG_EXP_LO:    st_nxt.exp_lo    = pwdata[AGE_EW-1:0];
            AGE_REG_EXP_HI:    st_nxt.exp_hi    = pwdata[AGE_EW-1:0];
            AGE_REG_DAMP:      st_nxt.damp      = (pwdata[7:0] > AGE_DAMP_MAX) ? AGE_DAMP_MAX : pwdata[7:0];
            AGE_REG_FRAME_MIN: st_nxt.frame_min = pwdata[AGE_EW-1:0];
            default:           st_nxt.gmode     = st_r.gmode;
         endcase
      end
      // Trigger-width mode forces exposure automation off
      if (st_nxt.trigw)
         st_nxt.emode = AGE_OFF;
      // Register reads
      case (paddr)
         AGE_REG_CTRL:      st_nxt.rdata = {26'h0, st_r.trigw, st_r.profile, st_r.emode, st_r.gmode};
         AGE_REG_TARGET:    st_nxt.rdata = {24'h0, st_r.target};
         AGE_REG_GAIN_LO:   st_nxt.rdata = {20'h0, st_r.gain_lo};
         AGE_REG_GAIN_HI:   st_nxt.rdata = {20'h0, st_r.gain_hi};
         AGE_REG_EXP_LO:    st_nxt.rdata = {8'h0, st_r.exp_lo};
         AGE_REG_EXP_HI:    st_nxt.rdata = {8'h0, st_r.exp_hi};
         AGE_REG_DAMP:      st_nxt.rdata = {24'h0, st_r.damp};
         AGE_REG_GAIN_MAN,
         AGE_REG_GAIN_OUT:  st_nxt.rdata = {20'h0, st_r.apply.gain_all};
         AGE_REG_EXP_MAN,
         AGE_REG_EXP_OUT:   st_nxt.rdata = {8'h0, st_r.apply.exposure};
         AGE_REG_STATUS:    st_nxt.rdata = {16'h0, st_r.avg, 6'h0, exp_na, overlap};
         AGE_REG_FRAME_MIN: st_nxt.rdata = {8'h0, st_r.frame_min};
         default:           st_nxt.rdata = 32'h0;
      endcase
      if (!(psel && !penable && !pwrite) && !rd_en)
         st_nxt.rdata = st_r.rdata;
      // Frame statistics over the region intersection
      if (pix.valid && pix.sof)
      begin
         st_nxt.sum = '0;
         st_nxt.cnt = '0;
      end
      if (pix.valid && in_win)
      begin
         st_nxt.sum = (pix.sof ? '0 : st_r.sum) + AGE_SW'(pix.value);
         st_nxt.cnt = (pix.sof ? '0 : st_r.cnt) + AGE_SW'(1);
      end
      if (pix.valid && pix.eof)
      begin
         st_nxt.avg_ok    = (st_nxt.cnt != '0) && overlap;
         st_nxt.avg       = (st_nxt.cnt != '0) ? 8'(st_nxt.sum / st_nxt.cnt) : st_r.avg;
         st_nxt.stats_new = 1'b1;
      end
      // One loop step per frame
      if (st_r.stats_new && st_r.avg_ok)
      begin
         if (g_act && use_gain && !at_target)
            st_nxt.gain_cur = gtmp[AGE_GW] ? (brighter ? ghi_c : glo_c)
                            : (gtmp[AGE_GW-1:0] > ghi_c) ? ghi_c
                            : (gtmp[AGE_GW-1:0] < glo_c) ? glo_c : gtmp[AGE_GW-1:0];
         if (e_act && !(g_act && use_gain) && !at_target)
            st_nxt.exp_cur = etmp[AGE_EW] ? (brighter ? ehi_c : elo_c)
                           : (etmp[AGE_EW-1:0] > ehi_c) ? ehi_c
                           : (etmp[AGE_EW-1:0] < elo_c) ? elo_c : etmp[AGE_EW-1:0];
         if (st_r.gmode == AGE_ONCE && (at_target || st_nxt.gain_cur == glo_c || st_nxt.gain_cur == ghi_c))
            st_nxt.gmode = AGE_OFF;
         if (st_r.emode == AGE_ONCE && (at_target || st_nxt.exp_cur == elo_c || st_nxt.exp_cur == ehi_c))
            st_nxt.emode = AGE_OFF;
      end
      // New values take effect only at a frame start
      if (pix.valid && pix.sof)
      begin
         st_nxt.apply.gain_all     = st_r.gain_cur;
         st_nxt.apply.exposure     = st_r.exp_cur;
         st_nxt.apply.frame_period = (st_r.exp_cur > st_r.frame_min) ? st_r.exp_cur : st_r.frame_min;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r                    <= '0;
         st_r.gmode              <= AGE_OFF;
         st_r.emode              <= AGE_OFF;
         st_r.target             <= AGE_TARGET_RST;
         st_r.damp               <= AGE_DAMP_RST;
         st_r.gain_hi            <= GAIN_ABS_MAX;
         st_r.gain_lo            <= GAIN_ABS_MIN;
         st_r.exp_lo             <= AGE_EXP_RST;
         st_r.exp_hi             <= AGE_EXP_HI_RST;
         st_r.frame_min          <= AGE_FRAME_RST;
         st_r.gain_cur           <= AGE_GAIN_RST;
         st_r.exp_cur            <= AGE_EXP_RST;
         st_r.apply.gain_all     <= AGE_GAIN_RST;
         st_r.apply.exposure     <= AGE_EXP_RST;
         st_r.apply.frame_period <= AGE_FRAME_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

endmodule : age_ctrl

// ===== hw/age_pkg.sv
// Package of constants, register map and types for the automatic gain and exposure controller
//
// Behaviour
// - Active gain automation steps all-tap gain within bounds toward the target average.
// - Per-tap gains are never touched by automation; only the all-tap gain.
// - Gain automation uses region one statistics; modes are off, once, continuous.
// - No overlap with image region: gain statistics ignored, manual gain applies.
// - Gain bound range depends on pixel format, binning and limit removal.
// - Target is 8-bit, 0 black to 255 white, same for 8 and 16-bit output.
// - Active exposure automation steps exposure within bounds toward the target average.
// - Automatic exposure and its bounds are not quantised to the time base.
// - No overlap with image region: exposure statistics ignored, manual exposure applies.
// - Exposure automation is unavailable while trigger-width exposure mode is selected.
// - Exposure longer than frame period lowers the frame rate.
// - Exposure bounds are clamped to model minimum and maximum exposure.
// - Switched-off automation keeps its latest value until a manual write.
// - Only pixels inside both regions contribute to the average.
// - Per-frame step scaled by damping 0.0 to 0.78125; higher converges faster.
// - Under combined automation the profile chooses whether gain or exposure stays low.
package age_pkg;

   // Register byte addresses
   localparam logic [7:0] AGE_REG_CTRL      = 8'h00;
   localparam logic [7:0] AGE_REG_TARGET    = 8'h04;
   localparam logic [7:0] AGE_REG_GAIN_MAN  = 8'h08;
   localparam logic [7:0] AGE_REG_GAIN_LO   = 8'h0c;
   localparam logic [7:0] AGE_REG_GAIN_HI   = 8'h10;
   localparam logic [7:0] AGE_REG_EXP_MAN   = 8'h14;
   localparam logic [7:0] AGE_REG_EXP_LO    = 8'h18;
   localparam logic [7:0] AGE_REG_EXP_HI    = 8'h1c;
   localparam logic [7:0] AGE_REG_DAMP      = 8'h20;
   localparam logic [7:0] AGE_REG_GAIN_OUT  = 8'h24;
   localparam logic [7:0] AGE_REG_EXP_OUT   = 8'h28;
   localparam logic [7:0] AGE_REG_STATUS    = 8'h2c;
   localparam logic [7:0] AGE_REG_FRAME_MIN = 8'h30;

   // Control register fields
   localparam int AGE_CTRL_GMODE_LSB = 0;
   localparam int AGE_CTRL_EMODE_LSB = 2;
   localparam int AGE_CTRL_PROFILE   = 4;
   localparam int AGE_CTRL_TRIGW     = 5;

   // Status register fields
   localparam int AGE_ST_OVERLAP = 0;
   localparam int AGE_ST_EXP_NA  = 1;
   localparam int AGE_ST_AVG_LSB = 8;

   // Widths
   localparam int AGE_GW = 12;
   localparam int AGE_EW = 24;
   localparam int AGE_CW = 12;
   localparam int AGE_SW = 40;

   // Reset values and damping limit
   localparam logic [7:0]        AGE_TARGET_RST  = 8'h80;
   localparam logic [7:0]        AGE_DAMP_RST    = 8'haf;
   localparam logic [7:0]        AGE_DAMP_MAX    = 8'hc8;
   localparam logic [AGE_GW-1:0] AGE_GAIN_RST    = 12'h000;
   localparam logic [AGE_EW-1:0] AGE_EXP_RST     = 24'h0003e8;
   localparam logic [AGE_EW-1:0] AGE_EXP_HI_RST  = 24'h0f4240;
   localparam logic [AGE_EW-1:0] AGE_FRAME_RST   = 24'h00c350;

   typedef enum logic [1:0] {AGE_OFF = 2'd0, AGE_ONCE = 2'd1, AGE_CONT = 2'd2} age_mode_t;

   // Per-frame statistics window
   typedef struct packed {
      logic [AGE_CW-1:0] x0;
      logic [AGE_CW-1:0] y0;
      logic [AGE_CW-1:0] w;
      logic [AGE_CW-1:0] h;
   } age_rect_t;

   // Pixel stream from the sensor pipeline
   typedef struct packed {
      logic              valid;
      logic              sof;
      logic              eof;
      logic [AGE_CW-1:0] x;
      logic [AGE_CW-1:0] y;
      logic [7:0]        value;
   } age_pix_t;

   // Values applied to the sensor
   typedef struct packed {
      logic [AGE_GW-1:0] gain_all;
      logic [AGE_EW-1:0] exposure;
      logic [AGE_EW-1:0] frame_period;
   } age_apply_t;

endpackage : age_pkg

// ===== verification/age_sensor_model.sv
// Sensor-side pixel source: 8x4 frames of one gray level
`timescale 1ns/100ps
module age_sensor_model
   import age_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic [7:0] level,
   output logic            busy,
   output age_pix_t        pix
);
   logic [4:0] cnt_r;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         busy  <= 1'b0;
         cnt_r <= 5'h00;
      end
      else if (busy)
      begin
         cnt_r <= cnt_r + 5'h01;
         busy  <= (cnt_r != 5'h1f);
      end
      else
         busy <= start;

   // Between frames the value line shows the inverse so a stale level is never read
   assign pix = '{busy, busy && cnt_r == 5'h00, busy && cnt_r == 5'h1f,
                  12'(cnt_r[2:0]), 12'(cnt_r[4:3]), busy ? level : ~level};
endmodule : age_sensor_model

// ===== verification/age_ctrl_chk.sv
// Port-level assertions for the gain and exposure controller
`timescale 1ns/100ps
module age_ctrl_chk
   import age_pkg::*;
#(
   parameter logic [AGE_EW-1:0] EXP_MODEL_MIN = 24'h000014,
   parameter logic [AGE_EW-1:0] EXP_MODEL_MAX = 24'h98967f
)
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic              pready,
   input wire logic [31:0]       prdata,
   input wire age_pix_t          pix,
   input wire logic [AGE_GW-1:0] gain_range_lo,
   input wire logic [AGE_GW-1:0] gain_range_hi,
   input wire age_apply_t        apply
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_ready_zero_wait: assert property (psel && penable |-> pready)
      else $error("pready low in access cycle");
   chk_apply_at_sof: assert property (!(pix.valid && pix.sof) |=> $stable(apply))
      else $error("applied values changed outside frame start");
   chk_period_covers: assert property (apply.frame_period >= apply.exposure)
      else $error("frame period shorter than exposure");
   chk_exp_clamp_hi: assert property (apply.exposure <= EXP_MODEL_MAX)
      else $error("exposure above model maximum");
   chk_exp_clamp_lo: assert property ($changed(apply.exposure) |-> apply.exposure >= EXP_MODEL_MIN)
      else $error("exposure below model minimum");
   chk_gain_range: assert property ($changed(apply.gain_all) |->
      apply.gain_all >= gain_range_lo && apply.gain_all <= gain_range_hi)
      else $error("gain outside permitted range");
   chk_gain_readback: assert property (psel && !penable && !pwrite && paddr == AGE_REG_GAIN_OUT
      && !(pix.valid && pix.sof) |=> prdata == 32'(apply.gain_all))
      else $error("gain readback differs from applied gain");
   chk_exp_readback: assert property (psel && !penable && !pwrite && paddr == AGE_REG_EXP_OUT
      && !(pix.valid && pix.sof) |=> prdata == 32'(apply.exposure))
      else $error("exposure readback differs from applied exposure");

   cover property ($changed(apply.gain_all));
   cover property ($changed(apply.exposure));
   cover property (apply.frame_period == apply.exposure);
endmodule : age_ctrl_chk

bind age_ctrl age_ctrl_chk #(.EXP_MODEL_MIN(EXP_MODEL_MIN), .EXP_MODEL_MAX(EXP_MODEL_MAX)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .prdata(prdata), .pix(pix), .gain_range_lo(gain_range_lo),
   .gain_range_hi(gain_range_hi), .apply(apply));

// ===== verification/testbench.sv
// Self-checking bench for the gain and exposure controller
`timescale 1ns/100ps
module testbench;
   import age_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic        start = 1'b0;
   logic        busy;
   logic [7:0]  level = 8'h00;
   age_pix_t    pix;
   age_rect_t   img = '{12'h000, 12'h000, 12'h008, 12'h004};
   age_apply_t  apply;
   logic [31:0] q;
   logic        qerr;
   int          miscompares = 0;
   int          n_compared = 0;

   always #10 pclk = ~pclk;

   age_ctrl #(.EXP_MODEL_MAX(24'h000600)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .pix(pix), .stat_region('{12'h000, 12'h000, 12'h008, 12'h004}),
      .image_region(img), .gain_range_lo(12'h004), .gain_range_hi(12'h200), .apply(apply));
   age_sensor_model i_src (.pclk(pclk), .presetn(presetn), .start(start), .level(level), .busy(busy), .pix(pix));

   ////////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : cmp

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      qerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task frames(input int n, input logic [7:0] lv);
      repeat (n)
      begin
         level <= lv;
         start <= 1'b1;
         @(posedge pclk);
         start <= 1'b0;
         @(posedge pclk);
         while (busy === 1'b1)
            @(posedge pclk);
         repeat (2) @(posedge pclk);
      end
   endtask : frames

   ////////////////////////////////////////////////////////////////////////////////
   task test_reset;
      cmp(32'(apply.gain_all), 32'(AGE_GAIN_RST), "gain reset");
      cmp(32'(apply.frame_period), 32'(AGE_FRAME_RST), "period reset");
      apb(1'b0, AGE_REG_TARGET, 32'h0);
      cmp(q, 32'(AGE_TARGET_RST), "target reset");
      apb(1'b0, AGE_REG_DAMP, 32'h0);
      cmp(q, 32'(AGE_DAMP_RST), "damping reset");
      apb(1'b1, AGE_REG_DAMP, 32'hff);
      apb(1'b0, AGE_REG_DAMP, 32'h0);
      cmp(q, 32'(AGE_DAMP_MAX), "damping limited to maximum");
      apb(1'b1, AGE_REG_DAMP, 32'(AGE_DAMP_RST));
      apb(1'b0, 8'h3c, 32'h0);
      cmp(q, 32'h0, "unmapped read");
      cmp(32'(qerr), 32'h0, "no error response");
      apb(1'b1, AGE_REG_TARGET, 32'hff);
      apb(1'b0, AGE_REG_TARGET, 32'h0);
      cmp(q, 32'hff, "target full white");
      apb(1'b1, AGE_REG_TARGET, 32'h80);
      $display("test reset done");
   endtask : test_reset

   task test_gain_loop;
      apb(1'b1, AGE_REG_GAIN_LO, 32'h010);
      apb(1'b1, AGE_REG_GAIN_HI, 32'h100);
      apb(1'b1, AGE_REG_CTRL, 32'h02);
      frames(6, 8'h20);
      cmp(32'(apply.gain_all), 32'h100, "continuous gain at upper bound");
      cmp(32'(apply.exposure), 32'(AGE_EXP_RST), "exposure untouched");
      apb(1'b1, AGE_REG_CTRL, 32'h01);
      frames(8, 8'hf0);
      apb(1'b0, AGE_REG_CTRL, 32'h0);
      cmp(q & 32'h3, 32'h0, "once mode returned to off");
      cmp(32'(apply.gain_all), 32'h010, "once gain at lower bound");
      frames(3, 8'h20);
      cmp(32'(apply.gain_all), 32'h010, "gain kept while off");
      apb(1'b0, AGE_REG_GAIN_OUT, 32'h0);
      cmp(q, 32'h010, "gain readback");
      $display("test gain loop done");
   endtask : test_gain_loop

   task test_combined;
      apb(1'b1, AGE_REG_FRAME_MIN, 32'h400);
      apb(1'b1, AGE_REG_EXP_LO, 32'h3e8);
      apb(1'b1, AGE_REG_EXP_HI, 32'h800);
      apb(1'b1, AGE_REG_CTRL, 32'h1a);
      frames(2, 8'h20);
      cmp(32'(apply.gain_all), 32'h010, "gain held low by profile");
      cmp(32'(apply.exposure > AGE_EXP_RST), 32'h1, "exposure raised");
      frames(3, 8'h20);
      cmp(32'(apply.exposure), 32'h600, "exposure clamped to model maximum");
      cmp(32'(apply.frame_period), 32'h600, "frame period follows exposure");
      apb(1'b0, AGE_REG_EXP_OUT, 32'h0);
      cmp(q, 32'h600, "exposure readback");
      $display("test combined done");
   endtask : test_combined

   task test_trigger_width;
      apb(1'b1, AGE_REG_CTRL, 32'h28);
      apb(1'b0, AGE_REG_CTRL, 32'h0);
      cmp((q >> 2) & 32'h3, 32'h0, "exposure mode forced off");
      apb(1'b0, AGE_REG_STATUS, 32'h0);
      cmp(q & 32'h2, 32'h2, "exposure unavailable flag");
      frames(3, 8'hf0);
      cmp(32'(apply.exposure), 32'h600, "exposure frozen");
      $display("test trigger width done");
   endtask : test_trigger_width

   task test_no_overlap;
      img <= '{12'h100, 12'h100, 12'h008, 12'h004};
      apb(1'b1, AGE_REG_CTRL, 32'h0a);
      apb(1'b1, AGE_REG_GAIN_MAN, 32'h055);
      apb(1'b1, AGE_REG_EXP_MAN, 32'h500);
      frames(3, 8'h20);
      cmp(32'(apply.gain_all), 32'h055, "manual gain rules");
      cmp(32'(apply.exposure), 32'h500, "manual exposure rules");
      apb(1'b0, AGE_REG_STATUS, 32'h0);
      cmp(q & 32'h1, 32'h0, "overlap flag clear");
      apb(1'b0, AGE_REG_CTRL, 32'h0);
      cmp(q & 32'hf, 32'ha, "both automations still continuous");
      $display("test no overlap done");
   endtask : test_no_overlap

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      test_reset;
      test_gain_loop;
      test_combined;
      test_trigger_width;
      test_no_overlap;
      test_done;
   end

   initial
   begin
      #100_000;
      miscompares++;
      test_done;
   end
endmodule : testbench
